/* File: design/nsc_regs.svh */
// Constants of the NAND status/ID/command host controller
`ifndef NSC_REGS_SVH
`define NSC_REGS_SVH

// Software register offsets
`define NSC_REG_CMD     4'h0
`define NSC_REG_STATUS  4'h1
`define NSC_REG_DSTAT   4'h2
`define NSC_REG_ID4     4'h3
`define NSC_REG_ID5     4'h4
`define NSC_REG_CTRL    4'h5
`define NSC_REG_PAGE    4'h6
// Device command codes
`define NSC_CMD_READ    8'h00
`define NSC_CMD_PROG    8'h10
`define NSC_CMD_MPROG   8'h11
`define NSC_CMD_CPROG   8'h15
`define NSC_CMD_CREAD   8'h31
`define NSC_CMD_STAT    8'h70
`define NSC_CMD_MSTAT   8'h71
`define NSC_CMD_SDIN    8'h80
`define NSC_CMD_COLCHG  8'h85
`define NSC_CMD_RESET   8'hFF
// Command register fields, address-cycle and partial-program limits
`define NSC_OP_CMD      2'h0
`define NSC_OP_ADDR     2'h1
`define NSC_OP_WDATA    2'h2
`define NSC_OP_RDATA    2'h3
`define NSC_PARTIAL_MAX 3'h4
`define NSC_ADDR_MAX    3'h5
// Strobe timing, in ns, converted to cycles at 8 ns
`define NSC_CLK_NS      8
`define NSC_STROBE_NS   24
`define NSC_STROBE_CYC  ((`NSC_STROBE_NS + `NSC_CLK_NS - 1) / `NSC_CLK_NS)
`endif

/* File: design/nsc_pkg.sv */
// Types of the NAND status/ID/command host controller
package nsc_pkg;
    typedef enum logic [2:0] {
        NSC_IDLE,
        NSC_SETUP,
        NSC_PULSE,
        NSC_HOLD,
        NSC_SAMPLE
    } nsc_state_t;
endpackage

/* File: design/nsc_host.sv */
// Host controller driving a NAND device over its command pins
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "nsc_regs.svh"
module nsc_host
    import nsc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    output logic             nand_ce_n,
    output logic             nand_cle,
    output logic             nand_ale,
    output logic             nand_we_n,
    output logic             read_strobe_n,
    output logic             nand_wp_n,
    input  wire logic [7:0]  nand_io_in,
    output logic      [7:0]  nand_io_out,
    output logic             nand_io_oe,
    input  wire logic        ready_busy_output
);
    nsc_state_t  state_q;
    logic [1:0]  op_q;
    logic [7:0]  byte_q;
    logic [7:0]  last_cmd_q;
    logic [7:0]  status_q;
    logic [7:0]  rdata_q;
    logic [7:0]  id4_q;
    logic [7:0]  id5_q;
    logic [2:0]  id_idx_q;
    logic        id_mode_q;
    logic        stat_mode_q;
    logic        sdin_q;
    logic [2:0]  addr_cnt_q;
    logic [2:0]  partial_q;
    logic [15:0] page_q;
    logic        order_err_q;
    logic        reject_q;
    logic        wp_q;
    logic [1:0]  cnt_q;
    logic [7:0]  io_m_q;
    logic [7:0]  io_s_q;
    logic        rb_m_q;
    logic        rb_s_q;
    logic        sample_q;
    logic        go;
    logic        allowed;
    logic [7:0]  cmd;

    // Two-stage synchronisers on device pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            io_m_q <= 8'h00;
            io_s_q <= 8'h00;
            rb_m_q <= 1'b0;
            rb_s_q <= 1'b0;
        end else begin
            io_m_q <= nand_io_in;
            io_s_q <= io_m_q;
            rb_m_q <= ready_busy_output;
            rb_s_q <= rb_m_q;
        end
    end

    // Device byte needs one more edge through the synchroniser before capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sample_q <= 1'b0;
        end else begin
            sample_q <= (state_q == NSC_SAMPLE);
        end
    end

    assign cmd = reg_wdata[7:0];

    // Command filter; busy covers power-on init too
    always_comb begin
        allowed = 1'b1;
        if (!rb_s_q) begin
            allowed = (cmd == `NSC_CMD_STAT) || (cmd == `NSC_CMD_MSTAT) || (cmd == `NSC_CMD_RESET);
        end else if (sdin_q) begin
            allowed = (cmd == `NSC_CMD_COLCHG) || (cmd == `NSC_CMD_PROG) || (cmd == `NSC_CMD_MPROG)
                      || (cmd == `NSC_CMD_CPROG) || (cmd == `NSC_CMD_RESET)
                      || (cmd == `NSC_CMD_STAT) || (cmd == `NSC_CMD_MSTAT);
        end
    end

    assign go = reg_wr && (reg_addr == `NSC_REG_CMD) && (state_q == NSC_IDLE)
                && ((reg_wdata[9:8] != `NSC_OP_CMD) || allowed)
                && !((reg_wdata[9:8] == `NSC_OP_ADDR) && (addr_cnt_q == `NSC_ADDR_MAX));

    // Pin strobe sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= NSC_IDLE;
            cnt_q   <= 2'h0;
            op_q    <= `NSC_OP_CMD;
            byte_q  <= 8'h00;
        end else begin
            unique case (state_q)
                NSC_IDLE: begin
                    if (go) begin
                        op_q    <= reg_wdata[9:8];
                        byte_q  <= cmd;
                        cnt_q   <= 2'h0;
                        state_q <= NSC_SETUP;
                    end
                end
                NSC_SETUP: state_q <= NSC_PULSE;
                NSC_PULSE: begin
                    cnt_q <= cnt_q + 2'h1;
                    if (cnt_q == 2'(`NSC_STROBE_CYC - 1)) begin
                        state_q <= (op_q == `NSC_OP_RDATA) ? NSC_SAMPLE : NSC_HOLD;
                    end
                end
                NSC_SAMPLE: state_q <= NSC_HOLD;
                NSC_HOLD: state_q <= NSC_IDLE;
            endcase
        end
    end

    // Pins follow the sequencer state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nand_ce_n     <= 1'b1;
            nand_cle      <= 1'b0;
            nand_ale      <= 1'b0;
            nand_we_n     <= 1'b1;
            read_strobe_n <= 1'b1;
            nand_io_out   <= 8'h00;
            nand_io_oe    <= 1'b0;
        end else begin
            nand_ce_n     <= (state_q == NSC_IDLE) && !go;
            nand_cle      <= (state_q != NSC_IDLE) && (op_q == `NSC_OP_CMD);
            nand_ale      <= (state_q != NSC_IDLE) && (op_q == `NSC_OP_ADDR);
            nand_we_n     <= !((state_q == NSC_PULSE) && (op_q != `NSC_OP_RDATA));
            read_strobe_n <= !((state_q == NSC_PULSE) && (op_q == `NSC_OP_RDATA));
            nand_io_out   <= byte_q;
            nand_io_oe    <= (state_q != NSC_IDLE) && (op_q != `NSC_OP_RDATA);
        end
    end

    // Command tracking and read data capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_cmd_q  <= `NSC_CMD_RESET;
            stat_mode_q <= 1'b0;
            id_mode_q   <= 1'b0;
            id_idx_q    <= 3'h0;
            sdin_q      <= 1'b0;
            addr_cnt_q  <= 3'h0;
            status_q    <= 8'h00;
            rdata_q     <= 8'h00;
            id4_q       <= 8'h00;
            id5_q       <= 8'h00;
            reject_q    <= 1'b0;
        end else begin
            if (reg_wr && (reg_addr == `NSC_REG_CMD) && !go) begin
                reject_q <= 1'b1;
            end else if (reg_wr && (reg_addr == `NSC_REG_CTRL) && reg_wdata[1]) begin
                reject_q <= 1'b0;
            end
            if (go && (reg_wdata[9:8] == `NSC_OP_CMD)) begin
                last_cmd_q <= cmd;
                addr_cnt_q <= 3'h0;
                id_mode_q  <= (cmd == 8'h90);
                id_idx_q   <= 3'h0;
                if (cmd == `NSC_CMD_STAT || cmd == `NSC_CMD_MSTAT) begin
                    stat_mode_q <= 1'b1;
                end else begin
                    stat_mode_q <= 1'b0;
                end
                if (cmd == `NSC_CMD_SDIN) begin
                    sdin_q <= 1'b1;
                end else if (cmd != `NSC_CMD_COLCHG && cmd != `NSC_CMD_STAT && cmd != `NSC_CMD_MSTAT) begin
                    sdin_q <= 1'b0;
                end
            end else if (go && (reg_wdata[9:8] == `NSC_OP_ADDR)) begin
                addr_cnt_q <= addr_cnt_q + 3'h1;
            end
            if (sample_q) begin
                rdata_q <= io_s_q;
                if (stat_mode_q) begin
                    status_q <= io_s_q;
                end else if (id_mode_q) begin
                    id_idx_q <= id_idx_q + 3'h1;
                    if (id_idx_q == 3'h3) id4_q <= io_s_q;
                    if (id_idx_q == 3'h4) id5_q <= io_s_q;
                end
            end
        end
    end

    // Ascending page order and partial program count per page
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            page_q      <= 16'h0000;
            partial_q   <= 3'h0;
            order_err_q <= 1'b0;
            wp_q        <= 1'b0;
        end else begin
            if (reg_wr && (reg_addr == `NSC_REG_CTRL)) begin
                wp_q <= reg_wdata[0];
                if (reg_wdata[1]) order_err_q <= 1'b0;
            end
            if (reg_wr && (reg_addr == `NSC_REG_PAGE)) begin
                if (reg_wdata == page_q) begin
                    if (partial_q == `NSC_PARTIAL_MAX) order_err_q <= 1'b1;
                    else partial_q <= partial_q + 3'h1;
                end else begin
                    if (reg_wdata < page_q) order_err_q <= 1'b1;
                    page_q    <= reg_wdata;
                    partial_q <= 3'h1;
                end
            end
        end
    end

    assign nand_wp_n = !wp_q;

    // Register read port; data one cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `NSC_REG_CMD:    reg_rdata <= {7'h00, state_q != NSC_IDLE, rdata_q};
                // Bit 6 mirrors bit 5 only outside cache ops; fail bits meaningless while busy
                `NSC_REG_STATUS: reg_rdata <= {last_cmd_q, status_q};
                `NSC_REG_DSTAT:  reg_rdata <= {10'h000, reject_q, order_err_q, sdin_q, stat_mode_q,
                                               !rb_s_q, rb_s_q};
                `NSC_REG_ID4:    reg_rdata <= {10'h000, id4_q[5:4], 2'h0, id4_q[1:0]};
                `NSC_REG_ID5:    reg_rdata <= {14'h0000, id5_q[3:2]};
                `NSC_REG_CTRL:   reg_rdata <= {15'h0000, wp_q};
                `NSC_REG_PAGE:   reg_rdata <= {page_q[12:0], partial_q};
                default:         reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

/* File: tb/nsc_host_monitor.sv */
// Pin and register-port checks for the NAND host controller
`timescale 1ns/1ps
`default_nettype none
module nsc_host_monitor (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        nand_ce_n,
    input wire logic        nand_cle,
    input wire logic        nand_we_n,
    input wire logic        read_strobe_n,
    input wire logic        nand_wp_n,
    input wire logic [7:0]  nand_io_out,
    input wire logic        nand_io_oe,
    input wire logic        ready_busy_output
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence we_pulse;
        !nand_we_n [*3] ##1 nand_we_n;
    endsequence
    sequence re_pulse;
        !read_strobe_n [*3] ##1 read_strobe_n;
    endsequence
    // Long enough that the synced copy inside is busy as well
    sequence long_busy;
        !ready_busy_output [*8];
    endsequence
    chk_we_width: assert property ($fell(nand_we_n) |-> we_pulse) else $error("write strobe width");
    chk_re_width: assert property ($fell(read_strobe_n) |-> re_pulse) else $error("read strobe width");
    chk_strobe_excl: assert property (nand_we_n || read_strobe_n) else $error("both strobes low");
    chk_strobe_sel: assert property (!(nand_we_n && read_strobe_n) |-> !nand_ce_n) else $error("no select");
    chk_read_float: assert property (!read_strobe_n |-> !nand_io_oe) else $error("bus driven in read");
    chk_busy_cmd: assert property (long_busy ##1 nand_cle && $fell(nand_we_n)
        |-> nand_io_out inside {8'h70, 8'h71, 8'hFF}) else $error("command sent while busy");
    chk_wp_set: assert property (reg_wr && reg_addr == 4'h5 && reg_wdata[0]
        |-> ##[1:2] !nand_wp_n) else $error("protect not applied");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("stray read data");
endmodule
bind nsc_host nsc_host_monitor nsc_host_monitor_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .nand_ce_n, .nand_cle, .nand_we_n, .read_strobe_n, .nand_wp_n, .nand_io_out, .nand_io_oe, .ready_busy_output);
`default_nettype wire

/* File: tb/nsc_dev_model.sv */
// Behavioural NAND device answering the host pins
`timescale 1ns/1ps
`default_nettype none
module nsc_dev_model #(
    parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
    parameter logic [7:0] DEV_ID   = 8'hC3  // Arbitrary value
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce_n,
    input  wire logic       cle,
    input  wire logic       we_n,
    input  wire logic       re_n,
    input  wire logic       wp_n,
    input  wire logic [7:0] io_in,
    input  wire logic [6:0] cfg,
    output logic      [7:0] io_out,
    output logic            rb
);
    logic [7:0]  cmd_q, out_q;
    logic [6:0]  busy_q;
    logic [2:0]  idx_q;
    logic        fail_q, we_q, re_q;
    logic [39:0] ids;
    assign ids = {4'h7, cfg[5:4], 4'h8, cfg[3:2], 2'b01, cfg[1:0], 8'h00, DEV_ID, MAKER_ID};
    assign rb = busy_q == 7'h00;
    // Released bus shows the inverse so a stale byte never passes
    assign io_out = ce_n ? ~out_q : out_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {busy_q, cmd_q, out_q, idx_q, fail_q, we_q, re_q} <= {7'h64, 16'h0000, 3'h0, 3'b011};
        end else begin
            we_q <= we_n;
            re_q <= re_n;
            if (busy_q != 7'h00) busy_q <= busy_q - 7'h01;
            // Addresses are not decoded, so a sixth cycle changes nothing
            if (!ce_n && cle && we_n && !we_q) begin
                cmd_q <= io_in;
                idx_q <= 3'h0;
                if (io_in == 8'hFF) {fail_q, busy_q} <= 8'h03;
                if (io_in == 8'h10 && wp_n) {fail_q, busy_q} <= {cfg[6], 7'h78};
            end
            if (!ce_n && !re_n && re_q) begin
                out_q <= (cmd_q == 8'h90) ? ids[{idx_q, 3'b000} +: 8] : {wp_n, rb, rb, 4'h0, fail_q};
                idx_q <= idx_q + 3'h1;
            end
            if (!wp_n) busy_q <= 7'h00;
        end
    end
endmodule
`default_nettype wire

/* File: tb/nsc_host_tb_top.sv */
// Self-checking bench for the NAND host controller
`timescale 1ns/1ps
`default_nettype none
module nsc_host_tb_top;
    logic        clk, rst, reg_wr, reg_rd, rd_q;
    logic        nand_ce_n, nand_cle, nand_ale, nand_we_n, read_strobe_n, nand_wp_n, nand_io_oe, ready_busy_output;
    logic [3:0]  reg_addr;
    logic [6:0]  cfg;
    logic [7:0]  nand_io_in, nand_io_out, dev_io;
    logic [15:0] reg_wdata, reg_rdata, last_q;
    logic [31:0] note, expq[$];
    int          n_errors = 0, samples_checked = 0;
    assign nand_io_in = nand_io_oe ? nand_io_out : dev_io;
    nsc_host nsc_host_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .nand_ce_n, .nand_cle,
        .nand_ale, .nand_we_n, .read_strobe_n, .nand_wp_n, .nand_io_in, .nand_io_out, .nand_io_oe, .ready_busy_output);
    nsc_dev_model nsc_dev_model_i (.clk, .rst, .ce_n(nand_ce_n), .cle(nand_cle), .we_n(nand_we_n),
        .re_n(read_strobe_n), .wp_n(nand_wp_n), .io_in(nand_io_in), .cfg, .io_out(dev_io), .rb(ready_busy_output));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        rd_q <= reg_rd;
        last_q <= reg_rdata;
        if (rd_q === 1'b1 && expq.size() > 0) begin
            note = expq.pop_front();
            samples_checked += (note[15:0] != 16'h0000);
            if ((reg_rdata & note[15:0]) !== (note[31:16] & note[15:0])) begin
                n_errors++;
                $display("Error at %0t: read %h, expected %h", $time, reg_rdata, note[31:16]);
            end
        end
    end
    task automatic complete_run();
        $display("Checks %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Extra edge after each strobe keeps back-to-back calls from clashing
    task automatic w(input logic [3:0] a, input logic [15:0] d);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic r(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        {reg_addr, reg_rd} <= {a, 1'b1};
        expq.push_back({e, m});
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic poll(input logic [3:0] a, input int b, input logic v);
        for (int n = 0; n < 300; n++) begin
            r(a, 16'h0000, 16'h0000);
            #1;
            if (last_q[b] === v) return;
        end
        n_errors++;
        $display("Error at %0t: wait ran out", $time);
        complete_run();
    endtask
    task automatic op(input logic [15:0] d);
        w(4'h0, d);
        poll(4'h0, 8, 1'b0);
    endtask
    task automatic st(input logic [7:0] e);
        op(16'h0070);
        op(16'h0300);
        r(4'h1, {8'h00, e}, 16'h00FF);
    endtask
    task automatic rej();
        r(4'h2, 16'h0020, 16'h0020);
        w(4'h5, 16'h0002);
    endtask
    initial begin
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 4'h0, 16'h0000};
        void'($urandom(43006));
        cfg = 7'($urandom());
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        op(16'h0090);
        rej();
        st(8'h80);
        poll(4'h2, 0, 1'b1);
        op(16'h0090);
        op(16'h0100);
        repeat (5) op(16'h0300);
        r(4'h3, {10'h000, cfg[3:2], 2'b00, cfg[1:0]}, 16'h0033);
        r(4'h4, {14'h0000, cfg[5:4]}, 16'h0003);
        op(16'h0080);
        repeat (6) op(16'h0100);
        rej();
        op(16'h0090);
        rej();
        op(16'h0010);
        poll(4'h2, 1, 1'b1);
        poll(4'h2, 0, 1'b1);
        st({7'h70, cfg[6]});
        op(16'h0080);
        op(16'h0010);
        w(4'h5, 16'h0001);
        st({7'h30, cfg[6]});
        w(4'h5, 16'h0000);
        op(16'h0080);
        op(16'h0010);
        op(16'h00FF);
        st(8'hE0);
        w(4'h6, 16'h0005);
        w(4'h6, 16'h0004);
        r(4'h2, 16'h0010, 16'h0010);
        w(4'h5, 16'h0002);
        repeat (4) w(4'h6, 16'h0004);
        r(4'h2, 16'h0010, 16'h0010);
        complete_run();
    end
endmodule
`default_nettype wire
